// file: rtl/bmf_pkg.sv
// Purpose: shared constants and types for the buck mode and fault latch block
// Assumes: 40 MHz block clock, APB register access
// Notes: qualification times are held in ns and turned into cycle counts here
package bmf_pkg;
  // clock rate and counter sizing
  localparam int CLK_MHZ = 40;
  localparam int CNT_W = 12;
  // qualification and timer periods, in ns
  localparam int OC_QUAL_NS = 10000;
  localparam int OV_QUAL_NS = 2000;
  localparam int US_TIMER_NS = 30000;
  // least times round up to whole cycles
  localparam logic [CNT_W-1:0] OC_CYC = CNT_W'((OC_QUAL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] OV_CYC = CNT_W'((OV_QUAL_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] US_CYC = CNT_W'((US_TIMER_NS * CLK_MHZ + 999) / 1000);
  // reverse-current cycles before diode emulation
  localparam logic [3:0] DEM_ENTRY_CYC = 4'h8;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATE_OFS = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0c;
  // interrupt event positions
  localparam int EV_OC = 0;
  localparam int EV_OV = 1;
  localparam int EV_DEM_IN = 2;
  localparam int EV_DEM_OUT = 3;
  localparam int EV_W = 4;
  // reset values
  localparam logic [EV_W-1:0] INT_MASK_RST = 4'h0;
  localparam logic CTRL_OFF_RST = 1'b0;

  // synchronised comparator and mode inputs
  typedef struct packed {
    logic pwm;
    logic phasePos;
    logic oc;
    logic fbRise;
    logic fbFall;
    logic en;
    logic por;
    logic pg;
    logic modeHi;
    logic modeFlt;
  } bmf_in_s;

  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } bmf_apb_s;
endpackage

// file: rtl/bmf_top.sv
// Purpose: conduction mode control, fault latches and gate gating for one buck channel
// Assumes: analog comparators deliver levels; pwmPulse is the loop's high-side command
// Notes: all state is one struct registered on mclk; apb answers one cycle into access
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module bmf_top import bmf_pkg::*; #(
  parameter bit CROWBAR = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pwmPulse,
  input wire logic phasePositive,
  input wire logic overcurrentComp,
  input wire logic fbAboveRise,
  input wire logic fbAboveFall,
  input wire logic enable,
  input wire logic porOk,
  input wire logic powerGoodFlag,
  input wire logic modeSelHigh,
  input wire logic modeSelFloat,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic highSideGate,
  output logic lowSideGate,
  output logic windowEnlarge,
  output logic powerGoodPullDown,
  output logic senseSourceOn,
  output logic irq
);

  typedef struct packed {
    bmf_in_s s1;
    bmf_in_s s2;
    logic pwmPrev;
    logic diode_emulation;
    logic [3:0] revCnt;
    logic revSeen;
    logic fwdSeen;
    logic lsOff;
    logic [1:0] loHist;
    logic usForce;
    logic [CNT_W-1:0] usCnt;
    logic [CNT_W-1:0] ocCnt;
    logic [CNT_W-1:0] ovCnt;
    logic [CNT_W-1:0] fallCnt;
    logic ocLat;
    logic ovLat;
    logic crowOn;
    logic pgSeen;
    logic senseOn;
    logic hiGate;
    logic loGate;
    logic winEn;
    logic pgPull;
    logic swOff;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] intSt;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bmf_state_s;

  // refuse a counter width too narrow for the qualification and timer counts
  if (CNT_W < 11) begin : g_chk
    $error("counter too narrow for the qualification counts");
  end

  bmf_state_s q;
  bmf_state_s d;
  bmf_in_s pin;
  bmf_apb_s bus;
  logic cycStart;
  logic off;
  logic [EV_W-1:0] ev;
  logic access;
  logic polValid;

  assign pin = '{pwmPulse, phasePositive, overcurrentComp, fbAboveRise, fbAboveFall,
                 enable, porOk, powerGoodFlag, modeSelHigh, modeSelFloat};
  assign bus = '{psel, penable, pwrite, paddr, pwdata};

  // next state of the whole block
  always_comb begin
    d = q;
    ev = '0;
    // two-stage synchroniser, first stage feeds only the second
    d.s1 = pin;
    d.s2 = q.s1;
    d.pwmPrev = q.s2.pwm;
    cycStart = q.s2.pwm && !q.pwmPrev;

    // synchronised polarity lags the pin by two cycles, so the gate must have
    // been on back then too; otherwise ringing of an idle node gets counted
    d.loHist = {q.loHist[0], q.loGate};
    polValid = q.loGate && q.loHist[1];
    // polarity only looked at while the low gate is on
    if (polValid && q.s2.phasePos) begin
      d.revSeen = 1'b1;
    end
    if (polValid && !q.s2.phasePos) begin
      d.fwdSeen = 1'b1;
    end
    // cut the low gate within a cycle on reverse current
    if (q.diode_emulation && polValid && q.s2.phasePos) begin
      d.lsOff = 1'b1;
    end

    // cycle boundary: count, enter or leave diode emulation
    if (cycStart) begin
      d.revSeen = 1'b0;
      d.fwdSeen = 1'b0;
      d.lsOff = 1'b0;
      if (!q.diode_emulation) begin
        d.revCnt = q.revSeen ? q.revCnt + 4'h1 : 4'h0;
        if (q.revSeen && q.revCnt + 4'h1 == DEM_ENTRY_CYC) begin
          d.diode_emulation = 1'b1;
          d.revCnt = 4'h0;
        end
      end else if (q.fwdSeen) begin
        d.diode_emulation = 1'b0;
      end
    end
    // forced continuous conduction overrides diode emulation
    if (q.s2.modeHi) begin
      d.diode_emulation = 1'b0;
      d.revCnt = 4'h0;
      d.lsOff = 1'b0;
    end
    if (d.diode_emulation && !q.diode_emulation) begin
      ev[EV_DEM_IN] = 1'b1;
    end
    if (!d.diode_emulation && q.diode_emulation) begin
      ev[EV_DEM_OUT] = 1'b1;
    end
    d.winEn = d.diode_emulation;

    // ultrasonic timer, restarted by each pulse
    if (cycStart) begin
      d.usCnt = '0;
      d.usForce = 1'b0;
    end else if (q.usCnt != US_CYC) begin
      d.usCnt = q.usCnt + CNT_W'(1);
    end
    if (q.usCnt == US_CYC && q.s2.modeFlt && q.diode_emulation && !cycStart) begin
      d.usForce = 1'b1;
    end

    // overcurrent qualification and latch
    d.ocCnt = q.s2.oc ? ((q.ocCnt == OC_CYC) ? q.ocCnt : q.ocCnt + CNT_W'(1)) : '0;
    if (q.ocCnt == OC_CYC && q.s2.oc && !q.ocLat) begin
      d.ocLat = 1'b1;
      ev[EV_OC] = 1'b1;
    end
    // overvoltage qualification and latch
    d.ovCnt = q.s2.fbRise ? ((q.ovCnt == OV_CYC) ? q.ovCnt : q.ovCnt + CNT_W'(1)) : '0;
    if (q.ovCnt == OV_CYC && q.s2.fbRise && !q.ovLat) begin
      d.ovLat = 1'b1;
      ev[EV_OV] = 1'b1;
    end
    // latches clear only on enable low or supply below reset threshold
    if (!q.s2.en || !q.s2.por) begin
      d.ocLat = 1'b0;
      d.ovLat = 1'b0;
    end
    d.pgPull = d.ocLat || d.ovLat;

    // soft crowbar: on above rising threshold, off after falling qualify
    d.fallCnt = !q.s2.fbFall ? ((q.fallCnt == OV_CYC) ? q.fallCnt : q.fallCnt + CNT_W'(1)) : '0;
    if (q.s2.fbRise) begin
      d.crowOn = 1'b1;
    end else if (q.fallCnt == OV_CYC && !q.s2.fbFall) begin
      d.crowOn = 1'b0;
    end
    if (!d.ovLat) begin
      d.crowOn = 1'b0;
    end

    // current-sense source during start-up until power good
    if (!q.s2.en || !q.s2.por) begin
      d.pgSeen = 1'b0;
    end else if (q.s2.pg) begin
      d.pgSeen = 1'b1;
    end
    d.senseOn = q.s2.en && q.s2.por && !d.pgSeen;

    // gate drive from the next-state latches
    off = d.ocLat || d.ovLat || !q.s2.en || !q.s2.por || q.swOff;
    d.hiGate = q.s2.pwm && !off;
    d.loGate = !q.s2.pwm && (!(d.diode_emulation && d.lsOff) || d.usForce) && !off;
    if (CROWBAR && d.ovLat && !d.ocLat) begin
      d.loGate = d.crowOn;
    end

    // apb slave: answer registered one cycle into the access phase
    access = bus.psel && bus.penable;
    d.pready = access && !q.pready;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (access && !q.pready) begin
      case (bus.paddr)
        CTRL_OFS: d.prdata = {31'h0, q.swOff};
        STATE_OFS: d.prdata = {24'h0, q.crowOn, q.senseOn, q.ovLat, q.ocLat,
                               q.usForce, q.winEn, q.s2.modeFlt, q.diode_emulation};
        INT_STAT_OFS: d.prdata = {28'h0, q.intSt};
        INT_MASK_OFS: d.prdata = {28'h0, q.mask};
        default: d.pslverr = 1'b1;
      endcase
      if (bus.pwrite) begin
        d.prdata = '0;
      end
    end
    // writes land at the edge that sees pready high
    if (access && q.pready && bus.pwrite) begin
      case (bus.paddr)
        CTRL_OFS: d.swOff = bus.pwdata[0];
        INT_STAT_OFS: d.intSt = q.intSt & ~bus.pwdata[EV_W-1:0];
        INT_MASK_OFS: d.mask = bus.pwdata[EV_W-1:0];
        default: d.swOff = q.swOff;
      endcase
    end
    // a new event wins over a clear in the same cycle
    d.intSt = d.intSt | ev;
    d.irq = |(d.intSt & d.mask);
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.mask <= INT_MASK_RST;
      q.swOff <= CTRL_OFF_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign highSideGate = q.hiGate;
  assign lowSideGate = q.loGate;
  assign windowEnlarge = q.winEn;
  assign powerGoodPullDown = q.pgPull;
  assign senseSourceOn = q.senseOn;
  assign irq = q.irq;

  // checks on the block's own behaviour
  localparam int OC_N = int'(OC_CYC);
  localparam int OV_N = int'(OV_CYC);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence demEntered;
    !q.diode_emulation ##1 q.diode_emulation;
  endsequence
  sequence latchedRun;
    q.ocLat && q.s2.en && q.s2.por;
  endsequence

  ccmHolds_a: assert property (q.s2.modeHi |=> !q.diode_emulation)
    else $error("diode emulation while forced continuous");
  demEntry_a: assert property (demEntered |-> $past(q.revCnt) == 7)
    else $error("diode emulation entered without eight reverse cycles");
  demWindow_a: assert property (demEntered |-> q.winEn)
    else $error("window not enlarged on diode emulation entry");
  demCut_a: assert property (q.diode_emulation && polValid && q.s2.phasePos && !cycStart
    |=> q.lsOff || !q.diode_emulation)
    else $error("reverse current did not cut low gate");
  ocQualify_a: assert property ($rose(q.ocLat) |-> $past(q.ocCnt) == OC_N)
    else $error("overcurrent latched before qualification time");
  ovQualify_a: assert property ($rose(q.ovLat) |-> $past(q.ovCnt) == OV_N)
    else $error("overvoltage latched before qualification time");
  ocHold_a: assert property (latchedRun |=> q.ocLat && q.pgPull)
    else $error("overcurrent latch released while enabled");
  hiOff_a: assert property (q.ocLat || q.ovLat |-> !q.hiGate && q.pgPull)
    else $error("high gate on while latched");
  triState_a: assert property (!CROWBAR && q.ovLat |-> !q.loGate)
    else $error("low gate on in tri-state latch");
  senseOff_a: assert property (q.pgSeen |-> !q.senseOn)
    else $error("sense source on after power good");
  usForce_a: assert property ($rose(q.usForce) |-> $past(q.usCnt) == int'(US_CYC))
    else $error("ultrasonic force before timer expiry");
  // a cut low gate stays off unless the timer or crowbar takes over
  lsCutGate_a: assert property (q.diode_emulation && q.lsOff && !q.usForce && !q.ovLat |-> !q.loGate)
    else $error("low gate on after reverse-current cut");
  // forward current seen in diode emulation leaves it at the boundary
  demExit_a: assert property (q.diode_emulation && q.fwdSeen && cycStart && !q.s2.modeHi |=> !q.diode_emulation)
    else $error("diode emulation kept after forward current");
  // each pulse restarts the ultrasonic timer
  usClear_a: assert property (cycStart |=> !q.usForce && q.usCnt == '0)
    else $error("ultrasonic timer not restarted by pulse");
  // the timer only forces the gate in floating mode
  usFloat_a: assert property ($rose(q.usForce) |-> $past(q.s2.modeFlt))
    else $error("ultrasonic force outside floating mode");
  // source stays on during start-up until power good is seen
  senseOn_a: assert property (q.s2.en && q.s2.por && !q.pgSeen && !q.s2.pg |=> q.senseOn)
    else $error("sense source off during start-up");
  // short overcurrent pulses leave no count behind
  ocShort_a: assert property (!q.s2.oc |=> q.ocCnt == '0)
    else $error("overcurrent count kept after comparator dropped");
  // enable low releases both fault latches
  latchClear_a: assert property (!q.s2.en |=> !q.ocLat && !q.ovLat)
    else $error("fault latch kept with enable low");
  // overvoltage latch holds while enabled and supplied
  ovHold_a: assert property (q.ovLat && q.s2.en && q.s2.por |=> q.ovLat)
    else $error("overvoltage latch released while enabled");
  // crowbar variant turns the low gate on above the rising threshold
  crowOn_a: assert property (CROWBAR && q.ovLat && q.s2.fbRise
    |=> q.loGate || !q.ovLat || q.ocLat)
    else $error("crowbar low gate not on above rising threshold");
endmodule
`default_nettype wire

// file: verif/bmf_phase_model.sv
// Purpose: switch-node polarity as seen by the low-side polarity comparator
// Assumes: reverseLoad high means the inductor current is negative
// Notes: polarity only means something while the low gate conducts
`timescale 1ns/1ps
`default_nettype none
module bmf_phase_model (
  input wire logic mclk,
  input wire logic lowSideGate,
  input wire logic reverseLoad,
  output logic phasePositive
);
  logic flip_q = 1'h0;
  // node rings while the low gate is off, so show a level that keeps changing
  always_ff @(posedge mclk) begin
    flip_q <= ~flip_q;
  end
  // reverse current lifts the node above ground while the low gate conducts
  assign phasePositive = lowSideGate ? reverseLoad : flip_q;
endmodule
`default_nettype wire

// file: verif/buck_mode_and_fault_latch_bench.sv
// Purpose: self-checking bench for the buck mode and fault latch block
// Assumes: tri-state overvoltage variant, power good raised early
// Notes: apb answers are matched against a queue of expected results
`timescale 1ns/1ps
`default_nettype none
module buck_mode_and_fault_latch_bench import bmf_pkg::*;;
  logic mclk = 1'h0, rst = 1'h1, pwmPulse = 1'h0, overcurrentComp = 1'h0;
  logic fbAboveRise = 1'h0, fbAboveFall = 1'h0, enable = 1'h0, porOk = 1'h0;
  logic powerGoodFlag = 1'h0, modeSelHigh = 1'h1, modeSelFloat = 1'h0, reverseLoad = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, highSideGate, lowSideGate, windowEnlarge;
  logic powerGoodPullDown, senseSourceOn, irq, phasePositive;
  logic [33:0] exq[$];
  logic [33:0] e;
  logic [3:0] m;
  int errors = 0, checked = 0;

  always #12.5 mclk = ~mclk;

  bmf_top #(.CROWBAR(1'h0)) i_dut (.mclk(mclk), .rst(rst), .pwmPulse(pwmPulse),
    .phasePositive(phasePositive), .overcurrentComp(overcurrentComp),
    .fbAboveRise(fbAboveRise), .fbAboveFall(fbAboveFall), .enable(enable), .porOk(porOk),
    .powerGoodFlag(powerGoodFlag), .modeSelHigh(modeSelHigh), .modeSelFloat(modeSelFloat),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .highSideGate(highSideGate),
    .lowSideGate(lowSideGate), .windowEnlarge(windowEnlarge),
    .powerGoodPullDown(powerGoodPullDown), .senseSourceOn(senseSourceOn), .irq(irq));
  bmf_phase_model i_far (.mclk(mclk), .lowSideGate(lowSideGate), .reverseLoad(reverseLoad),
    .phasePositive(phasePositive));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // sample settled outputs on the falling edge
  task automatic look(input int n);
    tick(n);
    @(negedge mclk);
  endtask
  task print_verdict;
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb transfer; the expectation is noted at setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic er);
    int n;
    @(posedge mclk);
    exq.push_back({er, ~w, x});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 10);
    if (n >= 10) chk(32'h0, 32'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // one switching cycle: short high pulse, then a long low phase
  task automatic swc(input logic rev, input logic expLo);
    @(posedge mclk) pwmPulse <= 1'h1;
    reverseLoad <= 1'h0;
    tick(4);
    pwmPulse <= 1'h0;
    reverseLoad <= rev;
    look(12);
    chk(32'(lowSideGate), 32'(expLo));
  endtask

  // answered transfers are matched against the oldest noted expectation
  always @(posedge mclk) begin
    if (pready === 1'h1) begin
      if (exq.size() == 0) chk(32'h0, 32'h1);
      else begin
        e = exq.pop_front();
        chk(32'(pslverr), 32'(e[33]));
        if (e[32]) chk(prdata, e[31:0]);
      end
    end
  end

  // main sequence
  initial begin
    void'($urandom(37195));
    m = 4'($urandom);
    look(15);
    chk(32'({highSideGate, lowSideGate, windowEnlarge, powerGoodPullDown, irq}), 32'h0);
    @(posedge mclk) rst <= 1'h0;
    enable <= 1'h1;
    porOk <= 1'h1;
    apb(1'h0, INT_MASK_OFS, 32'h0, 32'h0, 1'h0);
    apb(1'h1, INT_MASK_OFS, {28'h0, m}, 32'h0, 1'h0);
    apb(1'h0, INT_MASK_OFS, 32'h0, {28'h0, m}, 1'h0);
    apb(1'h0, 8'h10, 32'h0, 32'h0, 1'h1);
    apb(1'h1, 8'h14, 32'hffffffff, 32'h0, 1'h1);
    apb(1'h0, CTRL_OFS, 32'h0, 32'h0, 1'h0);
    look(4);
    chk(32'(senseSourceOn), 32'h1);
    @(posedge mclk) powerGoodFlag <= 1'h1;
    look(6);
    chk(32'(senseSourceOn), 32'h0);
    repeat (10) swc(1'h1, 1'h1);
    chk(32'(windowEnlarge), 32'h0);
    @(posedge mclk) modeSelHigh <= 1'h0;
    swc(1'h0, 1'h1);
    repeat (5) swc(1'h1, 1'h1);
    swc(1'h0, 1'h1);
    repeat (8) swc(1'h1, 1'h1);
    chk(32'(windowEnlarge), 32'h0);
    swc(1'h1, 1'h0);
    chk(32'(windowEnlarge), 32'h1);
    swc(1'h0, 1'h1);
    chk(32'(windowEnlarge), 32'h1);
    swc(1'h0, 1'h1);
    chk(32'(windowEnlarge), 32'h0);
    apb(1'h0, INT_STAT_OFS, 32'h0, 32'hc, 1'h0);
    look(2);
    chk(32'(irq), 32'(|m[3:2]));
    apb(1'h1, INT_MASK_OFS, 32'h0, 32'h0, 1'h0);
    look(2);
    chk(32'(irq), 32'h0);
    apb(1'h1, INT_MASK_OFS, 32'hf, 32'h0, 1'h0);
    look(2);
    chk(32'(irq), 32'h1);
    apb(1'h1, INT_STAT_OFS, 32'hc, 32'h0, 1'h0);
    apb(1'h0, INT_STAT_OFS, 32'h0, 32'h0, 1'h0);
    look(2);
    chk(32'(irq), 32'h0);
    @(posedge mclk) modeSelFloat <= 1'h1;
    swc(1'h0, 1'h1);
    repeat (8) swc(1'h1, 1'h1);
    swc(1'h1, 1'h0);
    look(1000);
    chk(32'(lowSideGate), 32'h0);
    look(250);
    chk(32'(lowSideGate), 32'h1);
    swc(1'h0, 1'h1);
    @(posedge mclk) modeSelFloat <= 1'h0;
    modeSelHigh <= 1'h1;
    pwmPulse <= 1'h1;
    look(5);
    chk(32'(highSideGate), 32'h1);
    @(posedge mclk) overcurrentComp <= 1'h1;
    tick(100 + $urandom % 250);
    overcurrentComp <= 1'h0;
    look(10);
    chk(32'(powerGoodPullDown), 32'h0);
    @(posedge mclk) overcurrentComp <= 1'h1;
    look(450);
    chk(32'({powerGoodPullDown, highSideGate, lowSideGate}), 32'h4);
    @(posedge mclk) overcurrentComp <= 1'h0;
    look(30);
    chk(32'({powerGoodPullDown, highSideGate}), 32'h2);
    @(posedge mclk) enable <= 1'h0;
    look(5);
    @(posedge mclk) enable <= 1'h1;
    look(10);
    chk(32'({powerGoodPullDown, highSideGate}), 32'h1);
    @(posedge mclk) {fbAboveRise, fbAboveFall} <= 2'h3;
    tick(60);
    {fbAboveRise, fbAboveFall} <= 2'h0;
    look(10);
    chk(32'(powerGoodPullDown), 32'h0);
    @(posedge mclk) {fbAboveRise, fbAboveFall} <= 2'h3;
    tick(100);
    {fbAboveRise, fbAboveFall} <= 2'h0;
    look(20);
    chk(32'({powerGoodPullDown, highSideGate}), 32'h2);
    @(posedge mclk) pwmPulse <= 1'h0;
    look(10);
    chk(32'({powerGoodPullDown, lowSideGate}), 32'h2);
    @(posedge mclk) porOk <= 1'h0;
    look(5);
    @(posedge mclk) porOk <= 1'h1;
    look(10);
    chk(32'({powerGoodPullDown, lowSideGate}), 32'h1);
    print_verdict();
  end

  // watchdog cuts a hang short
  initial begin
    tick(20000);
    errors++;
    $display("MISMATCH at %0t: timeout", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
